// ==== core/fault_latch_pkg.sv ====
// Constants, field layout and carrier types for the input fault latch bank.
// Assumes a control-port engine on sys_clk presents byte register accesses.
//
// What this block does
// - Summary bit 7 is set while input channel 1 holds any latched fault.
// - Summary bit 6 is set while input channel 2 holds any latched fault.
// - Summary bit 5 is set while output channel 1 holds any latched fault.
// - Summary bit 4 is set while output channel 2 holds any latched fault.
// - Summary bit 3 latches a battery short seen while battery is below bias.
// - Summary bits 2 to 0 are reserved and always read zero.
// - Channel 1 latch bit 7 records open inputs, cleared by reading.
// - Channel 1 latch bit 6 records legs shorted together, cleared by reading.
// - Channel 1 bits 5 and 4 record positive and negative leg ground shorts.
// - Channel 1 bits 3 and 2 record positive and negative leg bias shorts.
// - Channel 1 bits 1 and 0 record positive and negative leg battery shorts.
// - Channel 2 latch bit 7 records open inputs, cleared by reading.
// - Channel 2 latch bit 6 records legs shorted together, cleared by reading.
// - Channel 2 bits 5 and 4 record positive and negative leg ground shorts.
// - Channel 2 bits 3 and 2 record positive and negative leg bias shorts.
// - Channel 2 bits 1 and 0 record positive and negative leg battery shorts.
// - All three status registers are read-only; latch bits reset to zero, summary bits 5 and 4 follow the output flags.
// - Per-fault-type mask bit: zero passes fault to interrupt, one blocks it.
package fault_latch_pkg;

    localparam logic [7:0] ADDR_IRQ_MASK     = 8'h31;
    localparam logic [7:0] ADDR_SUMMARY      = 8'h35;
    localparam logic [7:0] ADDR_IN1_LATCH    = 8'h36;
    localparam logic [7:0] ADDR_IN2_LATCH    = 8'h37;

    localparam logic [7:0] RESET_BYTE        = 8'h00;
    localparam logic [7:0] ALL_ONES          = 8'hff;

    // Summary register bit positions
    localparam int         SUM_IN1_BIT       = 7;
    localparam int         SUM_IN2_BIT       = 6;
    localparam int         SUM_OUT1_BIT      = 5;
    localparam int         SUM_OUT2_BIT      = 4;
    localparam int         SUM_VBAT_BIT      = 3;
    localparam logic [2:0] SUM_RESERVED      = 3'h0;

    localparam int         NUM_IN_CH         = 2;

    // One input channel's fault bits, msb first as in the latch register
    typedef struct packed {
        logic open_inputs;
        logic legs_shorted;
        logic positive_input_leg_gnd;
        logic negative_input_leg_gnd;
        logic positive_input_leg_bias;
        logic negative_input_leg_bias;
        logic positive_input_leg_vbat;
        logic negative_input_leg_vbat;
    } input_faults_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ctrl_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
    } ctrl_resp_t;

endpackage

// ==== core/input_fault_latch_status.sv ====
// Read-only latched diagnostic status bank plus the input diagnostic mask.
// Fault detector levels are asynchronous; output-channel flags come from
// logic on sys_clk. Accesses arrive from the control-port engine.
`timescale 1ns/1ps
module input_fault_latch_status (
    input  wire logic                           sys_clk,
    input  wire logic                           rst,
    input  wire fault_latch_pkg::ctrl_req_t     ctrl_req,
    output fault_latch_pkg::ctrl_resp_t         ctrl_resp,
    input  wire fault_latch_pkg::input_faults_t in1_fault_raw,
    input  wire fault_latch_pkg::input_faults_t in2_fault_raw,
    input  wire logic                           out1_fault_any,
    input  wire logic                           out2_fault_any,
    input  wire logic                           vbat_short_low_raw,
    output logic                                diag_irq_request
);
    import fault_latch_pkg::*;

    function automatic logic hit(input ctrl_req_t req, input logic [7:0] target);
        hit = req.rd && (req.addr == target);
    endfunction

    // All checks run on sys_clk and rest while reset is held, except chk_reset_zero, which stays live during reset
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers: first stage feeds only the second
    logic [NUM_IN_CH-1:0][7:0] fault_meta;
    logic [NUM_IN_CH-1:0][7:0] fault_sync;
    logic                      vbat_meta;
    logic                      vbat_sync;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fault_meta <= '0;
            fault_sync <= '0;
            vbat_meta  <= 1'b0;
            vbat_sync  <= 1'b0;
        end else begin
            fault_meta <= {in2_fault_raw, in1_fault_raw};
            fault_sync <= fault_meta;
            vbat_meta  <= vbat_short_low_raw;
            vbat_sync  <= vbat_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-channel latches; a read clears, a live fault wins over the clear
    logic [NUM_IN_CH-1:0][7:0] latch;
    logic [NUM_IN_CH-1:0]      clear_rd;

    assign clear_rd[0] = hit(ctrl_req, ADDR_IN1_LATCH);
    assign clear_rd[1] = hit(ctrl_req, ADDR_IN2_LATCH);

    genvar g;
    generate
        for (g = 0; g < NUM_IN_CH; g++) begin : gen_ch
            logic [7:0] next_latch;
            always_comb begin
                next_latch = (latch[g] & (clear_rd[g] ? RESET_BYTE : ALL_ONES))
                           | fault_sync[g];
            end
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    latch[g] <= RESET_BYTE;
                end else begin
                    latch[g] <= next_latch;
                end
            end
        end
    endgenerate

    // Field views so each check names its fault instead of a bit index
    input_faults_t ch1_seen;
    input_faults_t ch2_seen;
    input_faults_t ch1_held;
    input_faults_t ch2_held;

    assign ch1_seen = fault_sync[0];
    assign ch2_seen = fault_sync[1];
    assign ch1_held = latch[0];
    assign ch2_held = latch[1];

    // A level seen at one edge is in the latch at the next, read or not
    chk_in1_open_set: assert property (
        ch1_seen.open_inputs |=> ch1_held.open_inputs)
        else $error("channel 1 open input not latched");
    chk_in1_short_set: assert property (
        ch1_seen.legs_shorted |=> ch1_held.legs_shorted)
        else $error("channel 1 shorted legs not latched");
    chk_in1_pgnd_set: assert property (
        ch1_seen.positive_input_leg_gnd |=> ch1_held.positive_input_leg_gnd)
        else $error("channel 1 positive leg ground short not latched");
    chk_in1_ngnd_set: assert property (
        ch1_seen.negative_input_leg_gnd |=> ch1_held.negative_input_leg_gnd)
        else $error("channel 1 negative leg ground short not latched");
    chk_in1_pbias_set: assert property (
        ch1_seen.positive_input_leg_bias |=> ch1_held.positive_input_leg_bias)
        else $error("channel 1 positive leg bias short not latched");
    chk_in1_nbias_set: assert property (
        ch1_seen.negative_input_leg_bias |=> ch1_held.negative_input_leg_bias)
        else $error("channel 1 negative leg bias short not latched");
    chk_in1_pvbat_set: assert property (
        ch1_seen.positive_input_leg_vbat |=> ch1_held.positive_input_leg_vbat)
        else $error("channel 1 positive leg battery short not latched");
    chk_in1_nvbat_set: assert property (
        ch1_seen.negative_input_leg_vbat |=> ch1_held.negative_input_leg_vbat)
        else $error("channel 1 negative leg battery short not latched");

    chk_in2_open_set: assert property (
        ch2_seen.open_inputs |=> ch2_held.open_inputs)
        else $error("channel 2 open input not latched");
    chk_in2_short_set: assert property (
        ch2_seen.legs_shorted |=> ch2_held.legs_shorted)
        else $error("channel 2 shorted legs not latched");
    chk_in2_pgnd_set: assert property (
        ch2_seen.positive_input_leg_gnd |=> ch2_held.positive_input_leg_gnd)
        else $error("channel 2 positive leg ground short not latched");
    chk_in2_ngnd_set: assert property (
        ch2_seen.negative_input_leg_gnd |=> ch2_held.negative_input_leg_gnd)
        else $error("channel 2 negative leg ground short not latched");
    chk_in2_pbias_set: assert property (
        ch2_seen.positive_input_leg_bias |=> ch2_held.positive_input_leg_bias)
        else $error("channel 2 positive leg bias short not latched");
    chk_in2_nbias_set: assert property (
        ch2_seen.negative_input_leg_bias |=> ch2_held.negative_input_leg_bias)
        else $error("channel 2 negative leg bias short not latched");
    chk_in2_pvbat_set: assert property (
        ch2_seen.positive_input_leg_vbat |=> ch2_held.positive_input_leg_vbat)
        else $error("channel 2 positive leg battery short not latched");
    chk_in2_nvbat_set: assert property (
        ch2_seen.negative_input_leg_vbat |=> ch2_held.negative_input_leg_vbat)
        else $error("channel 2 negative leg battery short not latched");

    ////////////////////////////////////////////////////////////////////////
    // Battery-below-bias short, sticky in the summary
    logic vbat_latch;
    logic next_vbat_latch;

    always_comb begin
        next_vbat_latch = (vbat_latch && !hit(ctrl_req, ADDR_SUMMARY)) || vbat_sync;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            vbat_latch <= 1'b0;
        end else begin
            vbat_latch <= next_vbat_latch;
        end
    end

    chk_vbat_read_clear: assert property (
        (hit(ctrl_req, ADDR_SUMMARY) && !vbat_sync) |=> !vbat_latch)
        else $error("battery short flag survived summary read");
    chk_vbat_set_wins: assert property (
        (hit(ctrl_req, ADDR_SUMMARY) && vbat_sync) |=> vbat_latch)
        else $error("live battery short lost to a read");

    ////////////////////////////////////////////////////////////////////////
    // Mask register and interrupt request
    logic [7:0] input_diag_irq_mask;
    logic [7:0] next_mask;
    logic       next_irq;

    always_comb begin
        next_mask = input_diag_irq_mask;
        if (ctrl_req.wr && ctrl_req.addr == ADDR_IRQ_MASK) begin
            next_mask = ctrl_req.wdata;
        end
        // Latch still records a masked fault; mask only gates the request
        next_irq = |((latch[0] | latch[1]) & ~input_diag_irq_mask);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            input_diag_irq_mask <= RESET_BYTE;
            diag_irq_request    <= 1'b0;
        end else begin
            input_diag_irq_mask <= next_mask;
            diag_irq_request    <= next_irq;
        end
    end

    chk_mask_write: assert property (
        (ctrl_req.wr && ctrl_req.addr == ADDR_IRQ_MASK)
        |=> input_diag_irq_mask == $past(ctrl_req.wdata))
        else $error("mask write did not land");
    chk_unmasked_irq: assert property (
        (((latch[0] | latch[1]) & ~input_diag_irq_mask) != RESET_BYTE) |=> diag_irq_request)
        else $error("unmasked fault gave no interrupt request");
    chk_masked_recorded: assert property (
        (input_diag_irq_mask == ALL_ONES && fault_sync[0] != RESET_BYTE)
        |=> latch[0] != RESET_BYTE)
        else $error("masked fault not recorded");

    ////////////////////////////////////////////////////////////////////////
    // Read path; data reflects the value before the clear-on-read
    logic [7:0] summary;
    ctrl_resp_t next_resp;

    always_comb begin
        summary               = RESET_BYTE;
        summary[SUM_IN1_BIT]  = |latch[0];
        summary[SUM_IN2_BIT]  = |latch[1];
        summary[SUM_OUT1_BIT] = out1_fault_any;
        summary[SUM_OUT2_BIT] = out2_fault_any;
        summary[SUM_VBAT_BIT] = vbat_latch;
        summary[2:0]          = SUM_RESERVED;
        next_resp.valid = ctrl_req.rd;
        next_resp.rdata = RESET_BYTE;
        if (ctrl_req.rd && ctrl_req.addr == ADDR_SUMMARY) begin
            next_resp.rdata = summary;
        end else if (ctrl_req.rd && ctrl_req.addr == ADDR_IN1_LATCH) begin
            next_resp.rdata = latch[0];
        end else if (ctrl_req.rd && ctrl_req.addr == ADDR_IN2_LATCH) begin
            next_resp.rdata = latch[1];
        end else if (ctrl_req.rd && ctrl_req.addr == ADDR_IRQ_MASK) begin
            next_resp.rdata = input_diag_irq_mask;
        end
    end

    // Writes to the status registers fall through unseen: read-only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_resp <= '0;
        end else begin
            ctrl_resp <= next_resp;
        end
    end

    chk_read_in1_data: assert property (
        hit(ctrl_req, ADDR_IN1_LATCH)
        |=> ctrl_resp.valid && ctrl_resp.rdata == $past(latch[0]))
        else $error("channel 1 read data is not the pre-clear value");
    chk_read_in2_data: assert property (
        hit(ctrl_req, ADDR_IN2_LATCH)
        |=> ctrl_resp.valid && ctrl_resp.rdata == $past(latch[1]))
        else $error("channel 2 read data is not the pre-clear value");
    chk_summary_out2: assert property (
        (hit(ctrl_req, ADDR_SUMMARY) && out2_fault_any)
        |=> ctrl_resp.valid && ctrl_resp.rdata[SUM_OUT2_BIT])
        else $error("summary bit 4 mismatch");
    chk_summary_vbat: assert property (
        hit(ctrl_req, ADDR_SUMMARY) |=> ctrl_resp.rdata[SUM_VBAT_BIT] == $past(vbat_latch))
        else $error("summary bit 3 mismatch");

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic       any_in1;
    logic       any_in2;
    logic [7:0] req_addr_q;
    assign any_in1 = |latch[0];
    assign any_in2 = |latch[1];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            req_addr_q <= RESET_BYTE;
        end else begin
            req_addr_q <= ctrl_req.addr;
        end
    end

    chk_read_clears_in1: assert property (
        (clear_rd[0] && fault_sync[0] == 8'h00) |=> latch[0] == 8'h00)
        else $error("channel 1 latch not cleared by read");
    chk_fault_sets_latch: assert property (
        (fault_sync[1] != 8'h00) |=> ((latch[1] & $past(fault_sync[1])) == $past(fault_sync[1])))
        else $error("channel 2 fault not latched");
    chk_latch_holds: assert property (
        (!clear_rd[0]) |=> ((latch[0] & $past(latch[0])) == $past(latch[0])))
        else $error("channel 1 latch lost without read");
    chk_summary_in1: assert property (
        (ctrl_req.rd && ctrl_req.addr == ADDR_SUMMARY) |=> ctrl_resp.rdata[7] == $past(any_in1))
        else $error("summary bit 7 mismatch");
    chk_summary_in2: assert property (
        (ctrl_req.rd && ctrl_req.addr == ADDR_SUMMARY) |=> ctrl_resp.rdata[6] == $past(any_in2))
        else $error("summary bit 6 mismatch");
    chk_summary_out: assert property (
        (ctrl_req.rd && ctrl_req.addr == ADDR_SUMMARY && out1_fault_any)
        |=> ctrl_resp.valid && ctrl_resp.rdata[5])
        else $error("summary bit 5 mismatch");
    chk_reserved_zero: assert property (
        (ctrl_resp.valid && req_addr_q == ADDR_SUMMARY) |-> ctrl_resp.rdata[2:0] == 3'h0)
        else $error("reserved summary bits nonzero");
    chk_vbat_sticky: assert property (
        vbat_sync |=> vbat_latch ##0 (vbat_latch || $past(ctrl_req.rd)))
        else $error("battery short not latched");
    chk_mask_blocks: assert property (
        (input_diag_irq_mask == 8'hff) |=> !diag_irq_request)
        else $error("masked fault raised interrupt");
    chk_read_only: assert property (
        (ctrl_req.wr && !ctrl_req.rd && ctrl_req.addr == ADDR_IN2_LATCH && fault_sync[1] == 8'h00)
        |=> latch[1] == $past(latch[1]))
        else $error("write altered status latch");

    chk_in2_read_clears: assert property (
        (clear_rd[1] && fault_sync[1] == RESET_BYTE) |=> latch[1] == RESET_BYTE)
        else $error("channel 2 latch not cleared by read");
    chk_in1_live_wins: assert property (
        (clear_rd[0] && fault_sync[0] != RESET_BYTE)
        |=> ((latch[0] & $past(fault_sync[0])) == $past(fault_sync[0])))
        else $error("channel 1 live fault lost to a read");
    chk_reset_zero: assert property (
        disable iff (1'b0)
        rst |=> (latch[0] == RESET_BYTE && latch[1] == RESET_BYTE && !vbat_latch
                 && ctrl_resp == '0 && !diag_irq_request))
        else $error("state not cleared by reset");

endmodule

// ==== bench/input_fault_latch_status_bench.sv ====
// Self-checking bench for the input fault latch status bank.
// Assumes the design and its package are compiled first; one 40 MHz clock.
`timescale 1ns/1ps
module input_fault_latch_status_bench;
    import fault_latch_pkg::*;
    logic          sys_clk     = 1'b0;
    logic          rst         = 1'b1;
    ctrl_req_t     req         = '0;
    ctrl_resp_t    resp;
    input_faults_t raw1        = '0;
    input_faults_t raw2        = '0;
    logic          out1        = 1'b0;
    logic          out2        = 1'b0;
    logic          vbat        = 1'b0;
    logic          irq;
    int            err_total   = 0;
    int            check_count = 0;

    always #12.5 sys_clk = ~sys_clk;

    input_fault_latch_status i_input_fault_latch_status (
        .sys_clk(sys_clk), .rst(rst), .ctrl_req(req), .ctrl_resp(resp),
        .in1_fault_raw(raw1), .in2_fault_raw(raw2), .out1_fault_any(out1),
        .out2_fault_any(out2), .vbat_short_low_raw(vbat), .diag_irq_request(irq));

////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Valid and data stand one cycle only, so both are taken at the next falling edge
    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        @(negedge sys_clk);
        req.rd   = 1'b1;
        req.addr = addr;
        @(negedge sys_clk);
        req.rd = 1'b0;
        check("read valid", 8'h01, {7'h00, resp.valid});
        check($sformatf("register %h", addr), exp, resp.rdata);
    endtask

    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge sys_clk);
        req.wr    = 1'b1;
        req.addr  = addr;
        req.wdata = data;
        @(negedge sys_clk);
        req.wr = 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        rd_chk(ADDR_SUMMARY, 8'h00);
        rd_chk(ADDR_IN1_LATCH, 8'h00);
        rd_chk(ADDR_IN2_LATCH, 8'h00);
        rd_chk(ADDR_IRQ_MASK, 8'h00);
        wr_reg(ADDR_IN1_LATCH, 8'hff);
        wr_reg(ADDR_SUMMARY, 8'hff);
        wr_reg(ADDR_IN2_LATCH, 8'hff);
        rd_chk(ADDR_IN1_LATCH, 8'h00);
        rd_chk(ADDR_SUMMARY, 8'h00);
        rd_chk(ADDR_IN2_LATCH, 8'h00);
        rd_chk(8'h40, 8'h00);
        $display("test_reset done");
    endtask

    // Pulse one detector bit at a time so a swapped bit position shows up
    task automatic test_each_bit();
        for (int ch = 0; ch < 2; ch++) begin
            for (int b = 0; b < 8; b++) begin
                if (ch == 0) raw1 = 8'h01 << b;
                else raw2 = 8'h01 << b;
                idle(4);
                raw1 = '0;
                raw2 = '0;
                idle(4);
                check("irq level", 8'h01, {7'h00, irq});
                rd_chk(ADDR_SUMMARY, (ch == 0) ? 8'h80 : 8'h40);
                rd_chk(ADDR_IN1_LATCH + ch[7:0], 8'h01 << b);
                rd_chk(ADDR_IN1_LATCH + ch[7:0], 8'h00);
            end
        end
        $display("test_each_bit done");
    endtask

    task automatic test_live();
        raw2.open_inputs = 1'b1;
        idle(5);
        rd_chk(ADDR_IN2_LATCH, 8'h80);
        rd_chk(ADDR_IN2_LATCH, 8'h80);
        raw2 = '0;
        idle(4);
        rd_chk(ADDR_IN2_LATCH, 8'h80);
        rd_chk(ADDR_IN2_LATCH, 8'h00);
        $display("test_live done");
    endtask

    task automatic test_summary();
        out1 = 1'b1;
        rd_chk(ADDR_SUMMARY, 8'h20);
        out1 = 1'b0;
        out2 = 1'b1;
        rd_chk(ADDR_SUMMARY, 8'h10);
        out2 = 1'b0;
        vbat = 1'b1;
        idle(4);
        rd_chk(ADDR_SUMMARY, 8'h08);
        vbat = 1'b0;
        idle(4);
        rd_chk(ADDR_SUMMARY, 8'h08);
        rd_chk(ADDR_SUMMARY, 8'h00);
        $display("test_summary done");
    endtask

    task automatic test_mask();
        wr_reg(ADDR_IRQ_MASK, 8'hff);
        rd_chk(ADDR_IRQ_MASK, 8'hff);
        raw1.negative_input_leg_vbat = 1'b1;
        idle(4);
        raw1 = '0;
        idle(4);
        check("irq masked", 8'h00, {7'h00, irq});
        wr_reg(ADDR_IRQ_MASK, 8'hfe);
        idle(2);
        check("irq unmasked", 8'h01, {7'h00, irq});
        wr_reg(ADDR_IRQ_MASK, 8'h00);
        rd_chk(ADDR_IN1_LATCH, 8'h01);
        idle(3);
        check("irq after clear", 8'h00, {7'h00, irq});
        $display("test_mask done");
    endtask

    // Reset in mid-run with faults, battery flag and mask all set
    task automatic test_reset_mid();
        raw1 = 8'h81;
        raw2 = 8'h42;
        vbat = 1'b1;
        wr_reg(ADDR_IRQ_MASK, 8'h0f);
        idle(4);
        check("irq before reset", 8'h01, {7'h00, irq});
        raw1 = '0;
        raw2 = '0;
        vbat = 1'b0;
        idle(2);
        rst = 1'b1;
        idle(3);
        rst = 1'b0;
        check("irq after reset", 8'h00, {7'h00, irq});
        rd_chk(ADDR_SUMMARY, 8'h00);
        rd_chk(ADDR_IN1_LATCH, 8'h00);
        rd_chk(ADDR_IN2_LATCH, 8'h00);
        rd_chk(ADDR_IRQ_MASK, 8'h00);
        $display("test_reset_mid done");
    endtask

////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Tests need well under a thousand cycles
    initial begin
        idle(5000);
        err_total++;
        end_of_test();
    end

    initial begin
        idle(20);
        rst = 1'b0;
        test_reset();
        test_each_bit();
        test_live();
        test_summary();
        test_mask();
        test_reset_mid();
        end_of_test();
    end
endmodule
